// [core/dual_ring_phase_sequencer.sv]
// phase selection and barrier sequencing for one or two timing rings
`timescale 1ns/1ps
`default_nettype none
module dual_ring_phase_sequencer (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // configuration: quadUnit high selects the single ring four phase frame
  input wire logic quadUnit,
  input wire logic dualEntry,
  // demand and interval status per phase
  input wire logic [7:0] vehCall,
  input wire logic [7:0] pedCall,
  input wire logic [7:0] phaseDone,
  input wire logic [7:0] pedStart,
  // phase indications
  output logic [7:0] phaseOn,
  output logic [7:0] phaseRed,
  output logic [7:0] pedRecycle,
  // barrier status
  output logic barrierCross,
  output logic activeSide
);

  localparam int NR = ring_seq_pkg::NUM_RINGS;
  localparam int NP = ring_seq_pkg::PH_PER_RING;

  ring_seq_pkg::ring_state_t state_r [NR];
  ring_seq_pkg::ring_state_t state_nxt [NR];
  logic [1:0] pos_r [NR];
  logic [1:0] pos_nxt [NR];
  logic side_r;
  logic side_nxt;
  logic cross_r;
  logic cross_nxt;
  logic [7:0] on_r;
  logic [7:0] on_nxt;
  logic [7:0] recyc_r;
  logic [7:0] recyc_nxt;
  logic crossShow_r;
  logic crossShow_nxt;
  logic [7:0] onPrev_r;
  logic [7:0] onPrev_nxt;

  logic [7:0] demand;
  logic [NR-1:0] atBarrier;
  logic [NR-1:0] ringIdle;
  logic [NR-1:0] ringActive;
  logic [NR-1:0] kFound;
  logic [NR-1:0] cFound;
  logic [1:0] kPos [NR];
  logic [1:0] cPos [NR];
  logic crossNow;
  logic [3:0] newSideMask;
  logic [1:0] dfltPos;

  // second ring takes no demand in the four phase frame
  always_comb begin
    demand = vehCall | pedCall;
    if (quadUnit) begin // [RQ11]
      demand[7:4] = 4'h0;
    end
  end

  assign newSideMask = side_r ? ring_seq_pkg::SIDE0_MASK : ring_seq_pkg::SIDE1_MASK;
  assign dfltPos = side_r ? ring_seq_pkg::DFLT_POS_SIDE0 : ring_seq_pkg::DFLT_POS_SIDE1;

  // crossing waits until every active ring has left service on this side
  always_comb begin
    crossNow = 1'b0;
    if (!quadUnit && (&atBarrier)) begin // [RQ2] [RQ3] [RQ12]
      // dual entry also crosses to refill a ring with no phase in service
      crossNow = (|demand) || (dualEntry && (|ringIdle)); // [RQ4] [RQ13]
    end
  end

  for (genvar r = 0; r < NR; r++) begin : g_ring
    logic [3:0] ringDem;
    logic [3:0] contMask;
    logic [1:0] contStart;
    logic doneNow;

    assign ringDem = demand[r*NP +: NP];
    assign contStart = pos_r[r] + 2'h1;
    assign doneNow = phaseDone[r*NP + int'(pos_r[r])];
    assign atBarrier[r] = (state_r[r] != ring_seq_pkg::RING_SERVE);
    assign ringIdle[r] = (state_r[r] == ring_seq_pkg::RING_IDLE);
    assign ringActive[r] = (state_r[r] == ring_seq_pkg::RING_SERVE)
      || (dualEntry && state_r[r] == ring_seq_pkg::RING_HOLD);

    // four phase frame allows any phase; otherwise same side only: the later phase of the pair may follow the earlier one
    always_comb begin
      if (quadUnit) begin
        contMask = ring_seq_pkg::ALL_MASK; // [RQ11]
      end else if (!pos_r[r][0]) begin
        contMask = 4'h1 << contStart;
      end else begin
        contMask = 4'h0; // [RQ2]
      end
    end

    ring_pick u_cont (
      .calls(ringDem),
      .allowed(contMask),
      .startPos(contStart),
      .found(kFound[r]),
      .pickPos(kPos[r])
    );

    ring_pick u_cross (
      .calls(ringDem),
      .allowed(newSideMask),
      .startPos({~side_r, 1'b0}),
      .found(cFound[r]),
      .pickPos(cPos[r])
    );

    // each ring steps on its own; only the barrier couples them
    always_comb begin
      state_nxt[r] = state_r[r];
      pos_nxt[r] = pos_r[r];
      if (quadUnit && r != 0) begin
        state_nxt[r] = ring_seq_pkg::RING_IDLE;
      end else begin
        unique case (state_r[r])
          ring_seq_pkg::RING_SERVE: begin
            if (doneNow) begin
              if (kFound[r]) begin
                pos_nxt[r] = kPos[r]; // [RQ1] [RQ14] [RQ9]
              end else begin
                state_nxt[r] = ring_seq_pkg::RING_HOLD;
              end
            end
          end
          ring_seq_pkg::RING_IDLE, ring_seq_pkg::RING_HOLD: begin
            if (quadUnit) begin
              if (kFound[r]) begin
                state_nxt[r] = ring_seq_pkg::RING_SERVE;
                pos_nxt[r] = kPos[r]; // [RQ10]
              end
            end else if (crossNow) begin
              if (cFound[r]) begin
                state_nxt[r] = ring_seq_pkg::RING_SERVE;
                pos_nxt[r] = cPos[r]; // [RQ9]
              end else if (dualEntry) begin
                state_nxt[r] = ring_seq_pkg::RING_SERVE;
                pos_nxt[r] = dfltPos; // [RQ5] [RQ4]
              end else begin
                // ring without demand sits out this side in red
                state_nxt[r] = ring_seq_pkg::RING_IDLE; // [RQ6] [RQ7]
              end
            end
          end
          default: begin
            state_nxt[r] = ring_seq_pkg::RING_IDLE;
          end
        endcase
      end
    end

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        state_r[r] <= ring_seq_pkg::RING_IDLE;
        pos_r[r] <= ring_seq_pkg::POS_RST;
      end else begin
        state_r[r] <= state_nxt[r];
        pos_r[r] <= pos_nxt[r];
      end
    end

    // one-hot indication from the ring's own position
    always_comb begin
      on_nxt[r*NP +: NP] = 4'h0;
      if (ringActive[r]) begin
        on_nxt[r*NP +: NP] = 4'h1 << pos_r[r]; // [RQ1] [RQ4]
      end
    end
  end

  // green must have stood a full cycle: a start on the first green cycle is normal service
  for (genvar p = 0; p < 8; p++) begin : g_ped
    assign recyc_nxt[p] = pedStart[p] && on_r[p] && onPrev_r[p]; // [RQ8]
  end

  always_comb begin
    side_nxt = side_r;
    cross_nxt = 1'b0;
    crossShow_nxt = cross_r;
    onPrev_nxt = on_r;
    if (crossNow) begin
      side_nxt = ~side_r; // [RQ2]
      cross_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      side_r <= ring_seq_pkg::SIDE_RST;
      cross_r <= 1'b0;
      crossShow_r <= 1'b0;
      on_r <= 8'h00;
      onPrev_r <= 8'h00;
      recyc_r <= 8'h00;
    end else begin
      side_r <= side_nxt;
      cross_r <= cross_nxt;
      crossShow_r <= crossShow_nxt;
      on_r <= on_nxt;
      onPrev_r <= onPrev_nxt;
      recyc_r <= recyc_nxt;
    end
  end

  // on_r lags ring state by one cycle, so the crossing pulse is delayed to meet it
  assign phaseOn = on_r;
  assign phaseRed = ~on_r; // [RQ7]
  assign pedRecycle = recyc_r;
  assign barrierCross = crossShow_r; // [RQ2]
  assign activeSide = side_r;

endmodule // dual_ring_phase_sequencer
`default_nettype wire

// [core/ring_seq_pkg.sv]
// constants and types shared by the dual ring phase sequencer
// Summary of operation
// RQ1: each ring serves its conflicting phases one at a time in fixed order
// RQ2: in dual ring both rings cross a barrier together, never one alone
// RQ3: two barriers keep conflicting phases of different rings from running together
// RQ4: with dual entry each ring always keeps exactly one phase in service
// RQ5: dual entry picks a preset default phase in a ring lacking calls at crossing
// RQ6: single entry lets one ring run alone when the other ring has no demand
// RQ7: the idle ring shows red on all its phases while the other runs alone
// RQ8: pedestrian service starting after its phase turned green flags a recycle
// RQ9: phases of the two rings are selected and timed concurrently and independently
// RQ10: with calls on every phase a ring walks its normal order
// RQ11: a four phase unit runs a single timing ring
// RQ12: an eight phase unit runs two rings of at most four phases
// RQ13: single entry is native; dual entry comes from an external request
// RQ14: uncalled phases are skipped, moving to the next called phase in order
package ring_seq_pkg;

  localparam int NUM_RINGS = 2;
  localparam int PH_PER_RING = 4;
  localparam int NUM_PHASES = NUM_RINGS * PH_PER_RING;

  // phases 0..1 of a ring sit left of the barrier, 2..3 right of it
  localparam logic [3:0] SIDE0_MASK = 4'h3;
  localparam logic [3:0] SIDE1_MASK = 4'hC;
  localparam logic [3:0] ALL_MASK = 4'hF;

  // dual entry default phase position per side (through movement)
  localparam logic [1:0] DFLT_POS_SIDE0 = 2'h1;
  localparam logic [1:0] DFLT_POS_SIDE1 = 2'h3;

  // reset values
  localparam logic [1:0] POS_RST = 2'h0;
  localparam logic SIDE_RST = 1'b1;

  typedef enum logic [1:0] {
    RING_IDLE = 2'b00,
    RING_SERVE = 2'b01,
    RING_HOLD = 2'b11
  } ring_state_t;

endpackage

// [core/ring_pick.sv]
// next called phase search within one ring
`timescale 1ns/1ps
`default_nettype none
module ring_pick (
  // search request
  input wire logic [3:0] calls,
  input wire logic [3:0] allowed,
  input wire logic [1:0] startPos,
  // result
  output logic found,
  output logic [1:0] pickPos
);

  logic [1:0] probe;

  // scan from startPos in ring order, wrapping, first allowed call wins
  always_comb begin
    found = 1'b0;
    pickPos = startPos;
    probe = startPos;
    for (int k = 0; k < 4; k++) begin
      probe = startPos + 2'(k);
      if (!found && calls[probe] && allowed[probe]) begin // [RQ14] [RQ10]
        found = 1'b1;
        pickPos = probe;
      end
    end
  end

endmodule // ring_pick
`default_nettype wire

// [test/ring_seq_props.sv]
// port assertions for the phase sequencer
`timescale 1ns/1ps
`default_nettype none
module ring_seq_props (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // watched ports
  input wire logic quadUnit,
  input wire logic dualEntry,
  input wire logic [7:0] pedStart,
  input wire logic [7:0] phaseOn,
  input wire logic [7:0] phaseRed,
  input wire logic [7:0] pedRecycle,
  input wire logic barrierCross,
  input wire logic activeSide
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [7:0] onLast_r;
  logic [7:0] recExp_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      onLast_r <= 8'h00;
      recExp_r <= 8'h00;
    end else begin
      onLast_r <= phaseOn;
      recExp_r <= pedStart & phaseOn & onLast_r;
    end
  end
  a_ring_one_phase: assert property ($onehot0(phaseOn[3:0]) && $onehot0(phaseOn[7:4]))
    else $error("two phases on in one ring");
  a_red_inverse: assert property (phaseRed == ~phaseOn)
    else $error("red is not the inverse of on");
  a_sides_apart: assert property (!(|phaseOn[1:0] && |phaseOn[7:6])
    && !(|phaseOn[3:2] && |phaseOn[5:4])) else $error("rings on opposite sides");
  a_cross_pulse: assert property ($changed(activeSide) |-> ##[0:1] barrierCross)
    else $error("side changed without crossing");
  a_cross_lands: assert property (barrierCross |->
    (phaseOn & (activeSide ? 8'h33 : 8'hCC)) == 8'h00) else $error("phase off new side");
  a_dual_fill: assert property (barrierCross && dualEntry && $past(dualEntry, 2) |->
    $onehot(phaseOn[3:0]) && $onehot(phaseOn[7:4])) else $error("ring empty in dual entry");
  a_quad_single: assert property (quadUnit && $past(quadUnit) |-> phaseOn[7:4] == 4'h0)
    else $error("second ring on in four phase frame");
  a_quad_nocross: assert property (quadUnit && $past(quadUnit) |-> !barrierCross)
    else $error("crossing in four phase frame");
  a_ped_recycle: assert property (pedRecycle == recExp_r)
    else $error("recycle pulse wrong");
endmodule // ring_seq_props
bind dual_ring_phase_sequencer ring_seq_props u_props (.clk(clk), .arst_n(arst_n),
  .quadUnit(quadUnit), .dualEntry(dualEntry), .pedStart(pedStart), .phaseOn(phaseOn),
  .phaseRed(phaseRed), .pedRecycle(pedRecycle), .barrierCross(barrierCross),
  .activeSide(activeSide));
`default_nettype wire

// [test/interval_timer.sv]
// interval timing stand-in that ends each served phase
`timescale 1ns/1ps
`default_nettype none
module interval_timer (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // slow holds each phase eight cycles
  input wire logic slow,
  // sequencer side
  input wire logic [7:0] phaseOn,
  output logic [7:0] phaseDone
);
  logic [2:0] cnt_r;
  logic [7:0] onLast_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 3'h0;
      onLast_r <= 8'h00;
    end else begin
      cnt_r <= (phaseOn != onLast_r) ? 3'h0 : cnt_r + 3'h1;
      onLast_r <= phaseOn;
    end
  end
  // only phases on for a full cycle end, so a fresh phase is never cut at once
  assign phaseDone = (slow && cnt_r != 3'h7) ? 8'h00 : phaseOn & onLast_r;
endmodule // interval_timer
`default_nettype wire

// [test/testbench.sv]
// self-checking bench for the phase sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic quadUnit = 1'b0;
  logic dualEntry = 1'b0;
  logic slow = 1'b0;
  logic [7:0] vehCall = 8'h00;
  logic [7:0] pedCall = 8'h00;
  logic [7:0] pedStart = 8'h00;
  logic [7:0] phaseDone, phaseOn, phaseRed, pedRecycle;
  logic barrierCross, activeSide;
  int err_total = 0;
  int compares = 0;
  always #5 clk = ~clk;
  dual_ring_phase_sequencer u_dut (.clk(clk), .arst_n(arst_n), .quadUnit(quadUnit),
    .dualEntry(dualEntry), .vehCall(vehCall), .pedCall(pedCall), .phaseDone(phaseDone),
    .pedStart(pedStart), .phaseOn(phaseOn), .phaseRed(phaseRed), .pedRecycle(pedRecycle),
    .barrierCross(barrierCross), .activeSide(activeSide));
  interval_timer u_timer (.clk(clk), .arst_n(arst_n), .slow(slow), .phaseOn(phaseOn),
    .phaseDone(phaseDone));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic restart(input logic quad, input logic dual, input logic slowMode);
    @(posedge clk);
    arst_n <= 1'b0;
    quadUnit <= quad;
    dualEntry <= dual;
    slow <= slowMode;
    vehCall <= 8'h00;
    pedCall <= 8'h00;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
  endtask
  task automatic wait_cross();
    repeat (60) begin
      @(negedge clk);
      if (barrierCross === 1'b1) return;
    end
    chk({7'h00, barrierCross}, 8'h01);
  endtask
  task automatic t_single();
    restart(1'b0, 1'b0, 1'b0);
    pedCall <= 8'h05;
    wait_cross();
    chk(phaseOn, 8'h01);
    chk(phaseRed, 8'hFE);
    chk({7'h00, activeSide}, 8'h00);
    wait_cross();
    chk(phaseOn, 8'h04);
    chk({7'h00, activeSide}, 8'h01);
    $display("single entry test done");
  endtask
  task automatic t_order(input logic quad, input logic slowMode);
    logic [3:0] last;
    int n;
    restart(quad, 1'b0, slowMode);
    vehCall <= 8'hFF;
    last = 4'h0;
    for (int i = 0; i < 5; i++) begin
      n = 0;
      while ((phaseOn[3:0] === 4'h0 || phaseOn[3:0] === last) && n < 200) begin
        @(negedge clk);
        n++;
      end
      if (i > 0) chk({4'h0, phaseOn[3:0]}, {4'h0, last[2:0], last[3]});
      else if (!quad) chk({4'h0, phaseOn[3:0]}, 8'h01);
      last = phaseOn[3:0];
    end
    $display("ring order test done");
  endtask
  task automatic t_dual();
    restart(1'b0, 1'b1, 1'b0);
    vehCall <= 8'h01;
    wait_cross();
    chk(phaseOn, 8'h21);
    @(posedge clk);
    vehCall <= 8'h04;
    wait_cross();
    chk(phaseOn, 8'h84);
    $display("dual entry test done");
  endtask
  task automatic t_ped();
    restart(1'b0, 1'b0, 1'b1);
    vehCall <= 8'h10;
    wait_cross();
    chk(phaseOn, 8'h10);
    @(posedge clk);
    pedStart <= 8'h10;
    @(posedge clk);
    pedStart <= 8'h00;
    @(negedge clk);
    chk(pedRecycle, 8'h10);
    @(negedge clk);
    chk(pedRecycle, 8'h00);
    $display("ped recycle test done");
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    finish_test();
  end
  initial begin
    t_single();
    t_order(1'b0, 1'b1);
    t_order(1'b1, 1'b0);
    t_dual();
    t_ped();
    finish_test();
  end
endmodule // testbench
`default_nettype wire
